// ---- src/ext_irq_cfg.svh ----
`ifndef EXT_IRQ_CFG_SVH
`define EXT_IRQ_CFG_SVH

// Register offsets (byte addresses)
`define OFS_IO_CTRL 12'h000
`define OFS_IRQ_STAT 12'h004
`define OFS_IRQ_MASK 12'h008
`define OFS_FIQ_MASK 12'h00c
`define OFS_PWR_MODE 12'h010

// Widths
`define STAT_W 24
`define IN_W 21
`define GP_W 8
`define OD_W 2

// Input vector and status bit positions
`define I_FALL 0
`define I_RISE 1
`define I_LOW_A 2
`define I_LOW_B 3
`define I_HSEL_A 4
`define I_LSEL_B 5
`define I_HIGH_C 6
`define I_LSEL_C 7
`define I_FAST 8
`define I_WAKE_A 9
`define I_WAKE_B 10
`define I_GP 11
`define I_OD 19
`define S_GP 16
`define S_GAP_LO 11
`define S_GAP_HI 15

// Routing allowed per status bit
`define IRQ_OK 24'hff06ff
`define FIQ_OK 24'h0001b0

// Reset values
`define RST_MASK 24'h000000
`define RST_GP_OE 8'h00
`define RST_OD_OE 2'h0

`endif

// ---- src/ext_irq_pkg.sv ----
package ext_irq_pkg;
`include "ext_irq_cfg.svh"

    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_STOP = 2'b01,
        MODE_SUSPEND = 2'b10
    } power_mode_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [`STAT_W-1:0] stat;
        logic [`STAT_W-1:0] irq_mask;
        logic [`STAT_W-1:0] fiq_mask;
        logic [`GP_W-1:0] gp_oe;
        logic [`OD_W-1:0] od_oe;
        power_mode_type mode;
        logic irq;
        logic fiq;
    } state_type;

endpackage

// ---- src/sync_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface sync_if #(parameter int W = 1) ();
    logic [W-1:0] raw;
    logic [W-1:0] level;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    logic valid;
    modport sync (input raw, output level, output rise, output fall, output valid);
    modport user (output raw, input level, input rise, input fall, input valid);
endinterface
`default_nettype wire

// ---- src/edge_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
    input wire logic pclk,
    input wire logic presetn,
    sync_if.sync sp
);
    localparam int W = $bits(sp.raw);

    if (W < 1) begin : g_chk
        $error("edge_sync needs at least one input");
    end

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] prev;
        logic [2:0] prime;
    } sync_state_type;

    sync_state_type st_r;
    sync_state_type st_nxt;

    // Two-flop chain, then one history stage for edges
    always_comb begin
        st_nxt = st_r;
        st_nxt.meta = sp.raw;
        st_nxt.sync = st_r.meta;
        st_nxt.prev = st_r.sync;
        st_nxt.prime = {st_r.prime[1:0], 1'b1};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Edges are suppressed until the history stage holds real samples
    assign sp.level = st_r.sync;
    assign sp.valid = st_r.prime[2];
    assign sp.rise = st_r.prime[2] ? (st_r.sync & ~st_r.prev) : '0;
    assign sp.fall = st_r.prime[2] ? (~st_r.sync & st_r.prev) : '0;
endmodule
`default_nettype wire

// ---- src/ext_irq_wake.sv ----
// Contract
// R01: First input requests only on a high-to-low transition.
// R02: First input's present level is readable in the I/O control register.
// R03: Second input's low-to-high transition raises the normal request.
// R04: Third and fourth inputs are active-low levels, normal request only.
// R05: Fifth input active-high, normal or fast request chosen by masks.
// R06: Sixth input active-low, normal or fast request chosen by masks.
// R07: Seventh input active-high level, normal request only.
// R08: Eighth input active-low, may raise fast or normal request.
// R09: Ninth input active-high, fast request only.
// R10: Falling edge of either wake input ends stop or suspend mode.
// R11: Eight port bits are software controlled and can raise interrupts.
// R12: Two open-drain lines are general I/O and never interrupt.
// R13: Inputs are synchronised; detected edges stay pending until cleared.
// R14: Level sources hold their active level until serviced.
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_cfg.svh"
module ext_irq_wake
    import ext_irq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_irq_fall_edge_n,
    input wire logic ext_irq_rise_edge,
    input wire logic ext_irq_low_a_n,
    input wire logic ext_irq_low_b_n,
    input wire logic ext_irq_high_sel_a,
    input wire logic ext_irq_low_sel_b_n,
    input wire logic ext_irq_high_c,
    input wire logic ext_irq_low_sel_c_n,
    input wire logic ext_fast_irq_high,
    input wire logic wake_event_a_n,
    input wire logic wake_event_b_n,
    input wire logic [`GP_W-1:0] gp_port_lines_in,
    output logic [`GP_W-1:0] gp_port_lines_out,
    output logic [`GP_W-1:0] gp_port_lines_oe,
    input wire logic [`OD_W-1:0] open_drain_lines_in,
    output logic [`OD_W-1:0] open_drain_lines_out,
    output logic [`OD_W-1:0] open_drain_lines_oe,
    output logic irq,
    output logic fiq,
    output logic [1:0] power_mode
);
    state_type st_r;
    state_type st_nxt;
    logic [`STAT_W-1:0] set_vec;
    logic [`STAT_W-1:0] clr_vec;
    logic [31:0] rd_mux;
    logic commit;

    sync_if #(.W(`IN_W)) pins_if ();

    // Every pin is brought onto pclk before use
    assign pins_if.raw = {
        open_drain_lines_in,
        gp_port_lines_in,
        wake_event_b_n,
        wake_event_a_n,
        ext_fast_irq_high,
        ext_irq_low_sel_c_n,
        ext_irq_high_c,
        ext_irq_low_sel_b_n,
        ext_irq_high_sel_a,
        ext_irq_low_b_n,
        ext_irq_low_a_n,
        ext_irq_rise_edge,
        ext_irq_fall_edge_n
    }; // R13

    edge_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .sp(pins_if.sync)
    );

    // Decode of the mapped register words
    function automatic logic reg_hit(input logic [11:0] a);
        reg_hit = (a == `OFS_IO_CTRL) || (a == `OFS_IRQ_STAT) || (a == `OFS_IRQ_MASK)
            || (a == `OFS_FIQ_MASK) || (a == `OFS_PWR_MODE);
    endfunction

    // Per-source request conditions
    always_comb begin
        set_vec = '0;
        if (pins_if.valid) begin
            set_vec[`I_FALL] = pins_if.fall[`I_FALL]; // R01
            set_vec[`I_RISE] = pins_if.rise[`I_RISE]; // R03
            set_vec[`I_LOW_A] = ~pins_if.level[`I_LOW_A]; // R04
            set_vec[`I_LOW_B] = ~pins_if.level[`I_LOW_B]; // R04
            set_vec[`I_HSEL_A] = pins_if.level[`I_HSEL_A]; // R05
            set_vec[`I_LSEL_B] = ~pins_if.level[`I_LSEL_B]; // R06
            set_vec[`I_HIGH_C] = pins_if.level[`I_HIGH_C]; // R07
            set_vec[`I_LSEL_C] = ~pins_if.level[`I_LSEL_C]; // R08
            set_vec[`I_FAST] = pins_if.level[`I_FAST]; // R09
            set_vec[`I_WAKE_A] = pins_if.fall[`I_WAKE_A]; // R10
            set_vec[`I_WAKE_B] = pins_if.fall[`I_WAKE_B]; // R10
            set_vec[`S_GP +: `GP_W] = pins_if.fall[`I_GP +: `GP_W]; // R11
        end
    end

    // Read data for the addressed word
    always_comb begin
        unique case (paddr)
            `OFS_IO_CTRL: rd_mux = {
                13'h0000,
                pins_if.level[`I_WAKE_B],
                pins_if.level[`I_WAKE_A],
                pins_if.level[`I_FALL], // R02
                6'h00,
                pins_if.level[`I_OD +: `OD_W],
                pins_if.level[`I_GP +: `GP_W]
            };
            `OFS_IRQ_STAT: rd_mux = {8'h00, st_r.stat};
            `OFS_IRQ_MASK: rd_mux = {8'h00, st_r.irq_mask};
            `OFS_FIQ_MASK: rd_mux = {8'h00, st_r.fiq_mask};
            `OFS_PWR_MODE: rd_mux = {30'h0, st_r.mode};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // APB slave, status, masks, port drive and power mode
    always_comb begin
        st_nxt = st_r;
        commit = psel && penable && st_r.pready;
        clr_vec = '0;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        if (psel && penable && !st_r.pready) begin
            st_nxt.pready = 1'b1;
            st_nxt.pslverr = !reg_hit(paddr);
            st_nxt.prdata = pwrite ? 32'h00000000 : rd_mux;
        end
        // Only bits that were returned are cleared, so a new event is kept
        if (commit && !pwrite && paddr == `OFS_IRQ_STAT) begin
            clr_vec = st_r.prdata[`STAT_W-1:0];
        end
        st_nxt.stat = (st_r.stat & ~clr_vec) | set_vec; // R13
        if (commit && pwrite) begin
            unique case (paddr)
                `OFS_IO_CTRL: begin
                    st_nxt.gp_oe = ~pwdata[`GP_W-1:0]; // R11
                    st_nxt.od_oe = ~pwdata[`GP_W +: `OD_W]; // R12
                end
                `OFS_IRQ_MASK: st_nxt.irq_mask = pwdata[`STAT_W-1:0] & `IRQ_OK;
                `OFS_FIQ_MASK: st_nxt.fiq_mask = pwdata[`STAT_W-1:0] & `FIQ_OK;
                `OFS_PWR_MODE: begin
                    if (pwdata[1:0] != 2'b11) begin
                        st_nxt.mode = power_mode_type'(pwdata[1:0]);
                    end
                end
                default: st_nxt.mode = st_r.mode;
            endcase
        end
        // A wake edge wins over a mode write in the same cycle
        if (set_vec[`I_WAKE_A] || set_vec[`I_WAKE_B]) begin
            st_nxt.mode = MODE_RUN; // R10
        end
        st_nxt.irq = |(st_nxt.stat & st_nxt.irq_mask & `IRQ_OK); // R04
        st_nxt.fiq = |(st_nxt.stat & st_nxt.fiq_mask & `FIQ_OK); // R09
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{
                prdata: 32'h00000000,
                pready: 1'b0,
                pslverr: 1'b0,
                stat: '0,
                irq_mask: `RST_MASK,
                fiq_mask: `RST_MASK,
                gp_oe: `RST_GP_OE,
                od_oe: `RST_OD_OE,
                mode: MODE_RUN,
                irq: 1'b0,
                fiq: 1'b0
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs; open-drain lines only ever pull low
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign gp_port_lines_out = '0;
    assign gp_port_lines_oe = st_r.gp_oe;
    assign open_drain_lines_out = '0;
    assign open_drain_lines_oe = st_r.od_oe;
    assign irq = st_r.irq;
    assign fiq = st_r.fiq;
    assign power_mode = st_r.mode;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Checks tied to the request logic
    fall_edge_a: assert property (pins_if.fall[`I_FALL] |=> st_r.stat[`I_FALL]) // R01
        else $error("falling edge not pended");
    rise_only_a: assert property ($rose(st_r.stat[`I_FALL]) |->
            $past(pins_if.fall[`I_FALL])) // R01
        else $error("first input pended without falling edge");
    level_read_a: assert property ((psel && penable && !st_r.pready && !pwrite // R02
            && paddr == `OFS_IO_CTRL) |=> st_r.prdata[16] == $past(pins_if.level[`I_FALL]))
        else $error("first input level not readable");
    rise_edge_a: assert property ((pins_if.rise[`I_RISE] && st_r.irq_mask[`I_RISE])
            |=> irq) // R03
        else $error("rising edge did not raise irq");
    low_level_a: assert property ((pins_if.valid && !pins_if.level[`I_LOW_A]) |=> // R04
            st_r.stat[`I_LOW_A] && !st_r.fiq_mask[`I_LOW_A])
        else $error("active-low level not pended");
    sel_route_a: assert property ((st_r.stat[`I_HSEL_A] && st_r.fiq_mask[`I_HSEL_A]
            && !st_r.stat[`I_FAST]) |-> fiq) // R05
        else $error("selectable source not routed to fiq");
    low_sel_a: assert property ((pins_if.valid && !pins_if.level[`I_LSEL_B]
            && st_r.irq_mask[`I_LSEL_B]) |=> irq) // R06
        else $error("selectable low source not routed to irq");
    high_c_a: assert property (st_r.fiq_mask[`I_HIGH_C] == 1'b0) // R07
        else $error("irq-only source routable to fiq");
    lsel_c_a: assert property ((st_r.stat[`I_LSEL_C] // R08
            && st_r.irq_mask[`I_LSEL_C]) |-> irq)
        else $error("eighth input not routed to irq");
    fast_only_a: assert property (!st_r.irq_mask[`I_FAST] && (!st_r.stat[`I_FAST] // R09
            || !st_r.fiq_mask[`I_FAST] || fiq))
        else $error("fast source routing wrong");
    wake_exit_a: assert property ((pins_if.fall[`I_WAKE_A] || pins_if.fall[`I_WAKE_B])
            |=> power_mode == MODE_RUN) // R10
        else $error("wake edge did not end low power");
    gp_src_a: assert property ((|pins_if.fall[`I_GP +: `GP_W]) |=>
            |st_r.stat[`S_GP +: `GP_W]) // R11
        else $error("port edge not pended");
    od_quiet_a: assert property (st_r.stat[`S_GAP_HI:`S_GAP_LO] == '0) // R12
        else $error("open-drain line raised a request");
    pend_hold_a: assert property ((st_r.stat[`I_FALL] && !(commit && !pwrite
            && paddr == `OFS_IRQ_STAT)) |=> st_r.stat[`I_FALL]) // R13
        else $error("pending edge lost without clear");

    // Checks on further levels, read clear, mode and port drive
    low_b_a: assert property ((pins_if.valid && !pins_if.level[`I_LOW_B]) |=> // R04
            st_r.stat[`I_LOW_B] && !st_r.fiq_mask[`I_LOW_B])
        else $error("second active-low level not pended");
    high_c_lvl_a: assert property ((pins_if.valid && pins_if.level[`I_HIGH_C]) |=> // R07
            st_r.stat[`I_HIGH_C])
        else $error("active-high level not pended");
    fast_lvl_a: assert property ((pins_if.valid && pins_if.level[`I_FAST]) |=> // R09
            st_r.stat[`I_FAST])
        else $error("fast level not pended");
    read_clear_a: assert property ((commit && !pwrite && paddr == `OFS_IRQ_STAT // R13
            && st_r.prdata[`I_FALL] && !set_vec[`I_FALL]) |=> !st_r.stat[`I_FALL])
        else $error("returned bit not cleared by read");
    mode_legal_a: assert property (power_mode != 2'b11) // R10
        else $error("illegal power mode");
    port_oe_a: assert property ((commit && pwrite && paddr == `OFS_IO_CTRL) |=> // R11
            gp_port_lines_oe == ~$past(pwdata[`GP_W-1:0]))
        else $error("port drive not written");
    od_oe_a: assert property ((commit && pwrite && paddr == `OFS_IO_CTRL) |=> // R12
            open_drain_lines_oe == ~$past(pwdata[`GP_W +: `OD_W]))
        else $error("open-drain drive not written");
endmodule
`default_nettype wire

// ---- dv/pin_source.sv ----
`timescale 1ns/1ps
`default_nettype none
// Far-side sources: request and wake pins, pulled-up port and open-drain lines
module pin_source (
    input wire logic [10:0] evt,
    input wire logic [7:0] gp_oe,
    input wire logic [1:0] od_oe,
    output logic [10:0] pins,
    output logic [7:0] gp_in,
    output logic [1:0] od_in
);
    // A request holds its active level while asked; low-true pins are inverted
    assign pins = evt ^ 11'h6ad;
    // Pull-ups hold a line high unless the device pulls it low
    assign gp_in = ~gp_oe;
    assign od_in = ~od_oe;
endmodule
`default_nettype wire

// ---- dv/external_interrupt_wake_inputs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_cfg.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module external_interrupt_wake_inputs_tb;
    localparam logic [10:0] IRQ_RT = 11'h6ff;
    localparam logic [10:0] FIQ_RT = 11'h1b0;
    localparam logic [10:0] LVL = 11'h1fc;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, fiq, err;
    logic [1:0] power_mode, od_out, od_oe, od_in;
    logic [7:0] gp_out, gp_oe, gp_in;
    logic [10:0] evt = 11'h000, pins;
    int fail_count = 0, n_tests = 0, cyc = 0;

    ext_irq_wake u_ext_irq_wake (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .ext_irq_fall_edge_n(pins[0]), .ext_irq_rise_edge(pins[1]),
        .ext_irq_low_a_n(pins[2]), .ext_irq_low_b_n(pins[3]),
        .ext_irq_high_sel_a(pins[4]), .ext_irq_low_sel_b_n(pins[5]),
        .ext_irq_high_c(pins[6]), .ext_irq_low_sel_c_n(pins[7]),
        .ext_fast_irq_high(pins[8]), .wake_event_a_n(pins[9]), .wake_event_b_n(pins[10]),
        .gp_port_lines_in(gp_in), .gp_port_lines_out(gp_out), .gp_port_lines_oe(gp_oe),
        .open_drain_lines_in(od_in), .open_drain_lines_out(od_out),
        .open_drain_lines_oe(od_oe), .irq(irq), .fiq(fiq), .power_mode(power_mode)
    );

    pin_source u_pin_source (
        .evt(evt), .gp_oe(gp_oe), .od_oe(od_oe), .pins(pins), .gp_in(gp_in), .od_in(od_in)
    );

    // Clock and run ceiling
    initial begin
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // One APB transfer; read data and error taken at the edge pready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        rchk("stat", `OFS_IRQ_STAT, 32'h0);
        rchk("mode", `OFS_PWR_MODE, 32'h0);
        rchk("io", `OFS_IO_CTRL, 32'h0007_03ff);
        `CHK("mapped", 1'b0, err)
        apb(1'b0, 12'h020, 32'h0);
        `CHK("unmapped", 1'b1, err)
        $display("test reset done");
        apb(1'b1, `OFS_IRQ_MASK, 32'hffff_ffff);
        apb(1'b1, `OFS_FIQ_MASK, 32'hffff_ffff);
        rchk("irq_mask", `OFS_IRQ_MASK, 32'h00ff_06ff);
        rchk("fiq_mask", `OFS_FIQ_MASK, 32'h0000_01b0);
        // Each source: routing, edge versus level, sticky until read
        for (int i = 0; i < 11; i++) begin
            evt[i] <= 1'b1;
            repeat (8) @(posedge pclk);
            `CHK("irq", IRQ_RT[i], irq)
            `CHK("fiq", FIQ_RT[i], fiq)
            rchk("stat set", `OFS_IRQ_STAT, 32'h1 << i);
            if (i == 0) rchk("fall lvl", `OFS_IO_CTRL, 32'h0006_03ff);
            evt[i] <= 1'b0;
            repeat (8) @(posedge pclk);
            rchk("stat again", `OFS_IRQ_STAT, LVL[i] ? 32'h1 << i : 32'h0);
            rchk("stat clear", `OFS_IRQ_STAT, 32'h0);
        end
        $display("test sources done");
        apb(1'b1, `OFS_IRQ_MASK, 32'h0);
        apb(1'b1, `OFS_FIQ_MASK, 32'h0);
        evt[8] <= 1'b1;
        repeat (8) @(posedge pclk);
        `CHK("masked irq", 1'b0, irq)
        `CHK("masked fiq", 1'b0, fiq)
        evt[8] <= 1'b0;
        repeat (8) @(posedge pclk);
        rchk("masked stat", `OFS_IRQ_STAT, 32'h100);
        $display("test mask done");
        apb(1'b1, `OFS_IO_CTRL, 32'h0000_015a);
        repeat (8) @(posedge pclk);
        `CHK("gp oe", 8'ha5, gp_oe)
        `CHK("od oe", 2'h2, od_oe)
        `CHK("gp out", 8'h00, gp_out)
        `CHK("od out", 2'h0, od_out)
        rchk("io lvl", `OFS_IO_CTRL, 32'h0007_015a);
        rchk("port stat", `OFS_IRQ_STAT, 32'h00a5_0000);
        apb(1'b1, `OFS_IO_CTRL, 32'h0000_03ff);
        $display("test port done");
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, `OFS_PWR_MODE, 32'(k + 1));
            rchk("mode set", `OFS_PWR_MODE, 32'(k + 1));
            `CHK("mode pin", 2'(k + 1), power_mode)
            evt[9 + k] <= 1'b1;
            repeat (8) @(posedge pclk);
            `CHK("woken", 2'h0, power_mode)
            evt[9 + k] <= 1'b0;
            repeat (8) @(posedge pclk);
            rchk("wake stat", `OFS_IRQ_STAT, 32'h200 << k);
        end
        apb(1'b1, `OFS_PWR_MODE, 32'h3);
        rchk("mode 3", `OFS_PWR_MODE, 32'h0);
        $display("test power done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
